//--- verilog/flash_ctl.sv
// Implementation choices: the Wishbone slave port and the address map.
module flash_ctl
   import flash_ctl_pkg::*;
#(
   parameter longint PROG_LIMIT = PROG_CYC,
   parameter longint PROG_ACC_LIMIT = PROG_ACC_CYC,
   parameter longint CHIP_LIMIT = CHIP_CYC,
   parameter longint CHIP_ACC_LIMIT = CHIP_ACC_CYC,
   parameter longint SECTOR_LIMIT = SECTOR_CYC,
   parameter longint SUSP_LIMIT = SUSP_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // interrupt
   output logic irq_o,
   // flash pins
   output logic [ADDR_W-1:0] fl_addr_o,
   output logic fl_ce_n_o,
   output logic fl_oe_n_o,
   output logic fl_we_n_o,
   output logic [DATA_W-1:0] fl_dq_o,
   output logic fl_dq_oe_o,
   input wire logic [DATA_W-1:0] fl_dq_i
);
   typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RGAP, S_RSTROBE, S_NEXT} state_t;
   state_t state_r;
   logic [2:0] op_r;
   logic accel_r;
   logic busy_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] prev_r;
   logic have_prev_r;
   logic polling_r;
   logic [2:0] step_r;
   logic [2:0] nsteps_r;
   logic [7:0] phase_r;
   logic [63:0] timer_r;
   logic [63:0] limit_r;
   logic [1:0] irq_r;
   logic [1:0] mask_r;
   logic timeout_r;
   logic ack_r;
   logic [DATA_W-1:0] dq_s1_r;
   logic [DATA_W-1:0] dq_s2_r;
   // bus decode
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
   wire wr_ctrl = bus_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0];
   wire wr_addr = bus_req && wb_we_i && wb_adr_i == REG_ADDR;
   wire wr_wdata = bus_req && wb_we_i && wb_adr_i == REG_WDATA;
   wire wr_irq = bus_req && wb_we_i && wb_adr_i == REG_IRQ && wb_sel_i[0];
   wire wr_mask = bus_req && wb_we_i && wb_adr_i == REG_MASK && wb_sel_i[0];
   wire start = wr_ctrl && wb_dat_i[CTRL_GO] && !busy_r;
   wire [2:0] new_op = wb_dat_i[CTRL_OP_LSB +: CTRL_OP_W];
   wire accel_nxt = wb_dat_i[CTRL_ACCEL];
   wire phase_done = phase_r == 8'(PHASE_CYC - 1);
   wire timed_out = timer_r >= limit_r;
   // completion only by comparing consecutive toggle bits
   wire toggle_same = prev_r[TOGGLE_BIT] == dq_s2_r[TOGGLE_BIT];
   wire op_polls = op_r == OP_PROGRAM || op_r == OP_CHIP_ERASE ||
                   op_r == OP_SECTOR_ERASE || op_r == OP_SUSPEND;
   // command sequence per step
   logic [ADDR_W-1:0] seq_addr;
   logic [DATA_W-1:0] seq_data;
   always_comb begin
      seq_addr = ADDR_W'(CMD_ADDR1);
      seq_data = CMD_AA;
      case (step_r)
         3'h0: begin
            seq_addr = ADDR_W'(CMD_ADDR1);
            seq_data = CMD_AA;
         end
         3'h1: begin
            seq_addr = ADDR_W'(CMD_ADDR2);
            seq_data = CMD_55;
         end
         3'h2: begin
            seq_addr = ADDR_W'(CMD_ADDR1);
            seq_data = (op_r == OP_PROGRAM) ? CMD_PROG : CMD_ERASE;
         end
         3'h3: begin
            seq_addr = (op_r == OP_PROGRAM) ? addr_r : ADDR_W'(CMD_ADDR1);
            seq_data = (op_r == OP_PROGRAM) ? wdata_r : CMD_AA;
         end
         3'h4: begin
            seq_addr = ADDR_W'(CMD_ADDR2);
            seq_data = CMD_55;
         end
         default: begin
            // final erase write picks chip or sector
            seq_addr = (op_r == OP_CHIP_ERASE) ? ADDR_W'(CMD_ADDR1) : addr_r;
            seq_data = (op_r == OP_CHIP_ERASE) ? CMD_CHIP : CMD_SECTOR;
         end
      endcase
      if (op_r == OP_WRITE) begin
         seq_addr = addr_r;
         seq_data = wdata_r;
      end
      if (op_r == OP_SUSPEND || op_r == OP_RESUME) begin
         seq_addr = addr_r;
         seq_data = (op_r == OP_SUSPEND) ? CMD_SUSP : CMD_RESUME;
      end
   end
   logic [63:0] limit_nxt;
   always_comb begin
      limit_nxt = 64'(SUSP_LIMIT);
      case (new_op)
         OP_PROGRAM: limit_nxt = accel_nxt ? 64'(PROG_ACC_LIMIT) : 64'(PROG_LIMIT);
         OP_CHIP_ERASE: limit_nxt = accel_nxt ? 64'(CHIP_ACC_LIMIT) : 64'(CHIP_LIMIT);
         OP_SECTOR_ERASE: limit_nxt = 64'(SECTOR_LIMIT);
         OP_SUSPEND: limit_nxt = 64'(SUSP_LIMIT);
         default: limit_nxt = 64'(SUSP_LIMIT);
      endcase
   end
   wire [2:0] steps_nxt = (new_op == OP_PROGRAM) ? 3'h4 :
                          (new_op == OP_CHIP_ERASE || new_op == OP_SECTOR_ERASE) ? 3'h6 :
                          3'h1;
   // read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case (wb_adr_i)
         REG_CTRL: rd_mux = {27'h0, accel_r, op_r, 1'b0};
         REG_ADDR: rd_mux = 32'(addr_r);
         REG_WDATA: rd_mux = 32'(wdata_r);
         REG_RDATA: rd_mux = 32'(rdata_r);
         REG_STATUS: rd_mux = {30'h0, timeout_r, busy_r};
         REG_IRQ: rd_mux = {30'h0, irq_r};
         REG_MASK: rd_mux = {30'h0, mask_r};
         REG_TIMER: rd_mux = timer_r[31:0];
         default: rd_mux = 32'h0;
      endcase
   end
   assign wb_ack_o = ack_r;
   assign irq_o = |(irq_r & mask_r);
   always_ff @(posedge clk_i) begin
      dq_s1_r <= fl_dq_i;
      dq_s2_r <= dq_s1_r;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         wb_dat_o <= 32'h0;
         addr_r <= '0;
         wdata_r <= '0;
         mask_r <= 2'h0;
         accel_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
         if (bus_req) wb_dat_o <= rd_mux;
         if (wr_addr) addr_r <= wb_dat_i[ADDR_W-1:0];
         if (wr_wdata) wdata_r <= wb_dat_i[DATA_W-1:0];
         if (wr_mask) mask_r <= wb_dat_i[1:0];
         if (wr_ctrl && !busy_r) accel_r <= wb_dat_i[CTRL_ACCEL];
      end
   end
   logic done_ev;
   logic to_ev;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_r <= 2'h0;
      end else begin
         irq_r <= (irq_r & ~(wr_irq ? wb_dat_i[1:0] : 2'h0)) | {to_ev, done_ev};
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
         op_r <= OP_READ;
         busy_r <= 1'b0;
         step_r <= 3'h0;
         nsteps_r <= 3'h0;
         phase_r <= 8'h0;
         timer_r <= 64'h0;
         limit_r <= 64'h0;
         rdata_r <= '0;
         prev_r <= '0;
         have_prev_r <= 1'b0;
         polling_r <= 1'b0;
         timeout_r <= 1'b0;
         done_ev <= 1'b0;
         to_ev <= 1'b0;
         fl_addr_o <= '0;
         fl_ce_n_o <= 1'b1;
         fl_oe_n_o <= 1'b1;
         fl_we_n_o <= 1'b1;
         fl_dq_o <= '0;
         fl_dq_oe_o <= 1'b0;
      end else begin
         done_ev <= 1'b0;
         to_ev <= 1'b0;
         phase_r <= phase_done ? 8'h0 : phase_r + 8'h1;
         if (polling_r) timer_r <= timer_r + 64'h1;
         case (state_r)
            S_IDLE: begin
               phase_r <= 8'h0;
               if (start) begin
                  op_r <= new_op;
                  busy_r <= 1'b1;
                  timeout_r <= 1'b0;
                  step_r <= 3'h0;
                  nsteps_r <= steps_nxt;
                  limit_r <= limit_nxt;
                  timer_r <= 64'h0;
                  have_prev_r <= 1'b0;
                  polling_r <= 1'b0;
                  state_r <= (new_op == OP_READ) ? S_RGAP : S_SETUP;
               end
            end
            S_SETUP: begin
               fl_addr_o <= seq_addr;
               fl_dq_o <= seq_data;
               fl_dq_oe_o <= 1'b1;
               fl_oe_n_o <= 1'b1;
               fl_ce_n_o <= 1'b0;
               if (phase_done) state_r <= S_STROBE;
            end
            S_STROBE: begin
               fl_we_n_o <= 1'b0;
               if (phase_done) state_r <= S_HOLD;
            end
            S_HOLD: begin
               fl_we_n_o <= 1'b1;
               if (phase_done) begin
                  fl_ce_n_o <= 1'b1;
                  fl_dq_oe_o <= 1'b0;
                  if (step_r == nsteps_r - 3'h1) begin
                     step_r <= 3'h0;
                     polling_r <= op_polls;
                     state_r <= op_polls ? S_RGAP : S_NEXT;
                  end else begin
                     step_r <= step_r + 3'h1;
                     state_r <= S_SETUP;
                  end
               end
            end
            S_RGAP: begin
               // poll address stays fixed across reads
               fl_addr_o <= addr_r;
               fl_ce_n_o <= 1'b1;
               fl_oe_n_o <= 1'b1;
               fl_dq_oe_o <= 1'b0;
               if (phase_done) state_r <= S_RSTROBE;
            end
            S_RSTROBE: begin
               // each poll read is its own oe and ce pulse
               fl_ce_n_o <= 1'b0;
               fl_oe_n_o <= 1'b0;
               if (phase_done) begin
                  fl_ce_n_o <= 1'b1;
                  fl_oe_n_o <= 1'b1;
                  prev_r <= dq_s2_r;
                  have_prev_r <= 1'b1;
                  if (!polling_r) begin
                     rdata_r <= dq_s2_r;
                     state_r <= S_NEXT;
                  end else if (have_prev_r && toggle_same) begin
                     rdata_r <= dq_s2_r;
                     state_r <= S_NEXT;
                  end else if (timed_out) begin
                     timeout_r <= 1'b1;
                     to_ev <= 1'b1;
                     state_r <= S_NEXT;
                  end else begin
                     state_r <= S_RGAP;
                  end
               end
            end
            S_NEXT: begin
               busy_r <= 1'b0;
               polling_r <= 1'b0;
               done_ev <= 1'b1;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule : flash_ctl

//--- verilog/flash_ctl_pkg.sv
package flash_ctl_pkg;
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   // wishbone register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ = 8'h14;
   localparam logic [7:0] REG_MASK = 8'h18;
   localparam logic [7:0] REG_TIMER = 8'h1c;
   // control fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LSB = 1;
   localparam int CTRL_OP_W = 3;
   localparam int CTRL_ACCEL = 4;
   // irq fields
   localparam int IRQ_DONE = 0;
   localparam int IRQ_TIMEOUT = 1;
   // operations
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_PROGRAM = 3'h2;
   localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
   localparam logic [2:0] OP_SECTOR_ERASE = 3'h4;
   localparam logic [2:0] OP_SUSPEND = 3'h5;
   localparam logic [2:0] OP_RESUME = 3'h6;
   // command codes
   localparam logic [15:0] CMD_ADDR1 = 16'h0555;
   localparam logic [15:0] CMD_ADDR2 = 16'h0aaa;
   localparam logic [15:0] CMD_AA = 16'h00aa;
   localparam logic [15:0] CMD_55 = 16'h0055;
   localparam logic [15:0] CMD_PROG = 16'h00a0;
   localparam logic [15:0] CMD_ERASE = 16'h0080;
   localparam logic [15:0] CMD_CHIP = 16'h0010;
   localparam logic [15:0] CMD_SECTOR = 16'h0030;
   localparam logic [15:0] CMD_SUSP = 16'h00b0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;
   localparam int TOGGLE_BIT = 6;
   // bus cycle phase, in clocks of 10 ns
   localparam int T_PHASE_NS = 100;
   localparam int PHASE_CYC = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
   // operation time limits
   localparam int T_PROG_US = 50;
   localparam int T_PROG_ACC_US = 25;
   localparam int T_CHIP_S = 12;
   localparam int T_CHIP_ACC_S = 6;
   localparam int T_SECTOR_MS = 400;
   localparam int T_SUSP_US = 15;
   localparam longint PROG_CYC = longint'(T_PROG_US) * CLK_MHZ;
   localparam longint PROG_ACC_CYC = longint'(T_PROG_ACC_US) * CLK_MHZ;
   localparam longint CHIP_CYC = longint'(T_CHIP_S) * 1000000 * CLK_MHZ;
   localparam longint CHIP_ACC_CYC = longint'(T_CHIP_ACC_S) * 1000000 * CLK_MHZ;
   localparam longint SECTOR_CYC = longint'(T_SECTOR_MS) * 1000 * CLK_MHZ;
   localparam longint SUSP_CYC = longint'(T_SUSP_US) * CLK_MHZ;
endpackage : flash_ctl_pkg

//--- test/flash_ctl_properties.sv
module flash_ctl_properties
   import flash_ctl_pkg::*;
(
   // watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire logic [ADDR_W-1:0] fl_addr_o,
   input wire logic fl_ce_n_o,
   input wire logic fl_oe_n_o,
   input wire logic fl_we_n_o,
   input wire logic fl_dq_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [ADDR_W-1:0] rd_addr_r;
   logic rd_seen_r;
   wire ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == REG_CTRL;
   wire mask_off = wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_MASK
      && wb_dat_i[1:0] == 2'b00;
   // polls of one operation share an address
   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_wr) rd_seen_r <= 1'b0;
      else if ($fell(fl_oe_n_o)) rd_seen_r <= 1'b1;
      if ($fell(fl_oe_n_o)) rd_addr_r <= fl_addr_o;
   end
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack late");
   property p_oe_write; !fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o && fl_dq_oe_o; endproperty
   a_oe_write: assert property (p_oe_write) else $error("oe low in write");
   property p_read_quiet; !fl_oe_n_o |-> fl_we_n_o && !fl_dq_oe_o; endproperty
   a_read_quiet: assert property (p_read_quiet) else $error("drive in read");
   property p_we_width;
      $fell(fl_we_n_o) |-> !fl_we_n_o [*8] ##1 !fl_we_n_o [*2] ##1 fl_we_n_o;
   endproperty
   a_we_width: assert property (p_we_width) else $error("strobe width");
   property p_read_pulse;
      $fell(fl_oe_n_o) |-> (!fl_ce_n_o && !fl_oe_n_o) [*8] ##[1:4] fl_oe_n_o;
   endproperty
   a_read_pulse: assert property (p_read_pulse) else $error("read pulse");
   property p_poll_addr; $fell(fl_oe_n_o) && rd_seen_r |-> fl_addr_o == rd_addr_r; endproperty
   a_poll_addr: assert property (p_poll_addr) else $error("poll address moved");
   property p_mask_off; mask_off |=> !irq_o; endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq while masked");
   property p_ce_idle; fl_ce_n_o |-> fl_oe_n_o && fl_we_n_o; endproperty
   a_ce_idle: assert property (p_ce_idle) else $error("strobe without select");
   c_write: cover property ($fell(fl_we_n_o));
   c_poll: cover property ($fell(fl_oe_n_o) && rd_seen_r);
   c_irq: cover property ($rose(irq_o));
endmodule : flash_ctl_properties
bind flash_ctl flash_ctl_properties chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .irq_o, .fl_addr_o, .fl_ce_n_o, .fl_oe_n_o,
   .fl_we_n_o, .fl_dq_oe_o);

//--- test/flash_dev_model.sv
module flash_dev_model
   import flash_ctl_pkg::*;
(
   // host pins
   input wire logic clk_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] last_d, prog_d, last_q = '0;
   logic [ADDR_W-1:0] last_a;
   int busy_cyc = 200;
   int left = 0;
   bit ers, arm_p, arm_e, susp;
   bit tog = 1'b1; // start value arbitrary
   wire rd = !ce_n_i && !oe_n_i;
   always @(posedge we_n_i) if (!ce_n_i) begin
      last_a = addr_i;
      last_d = dq_i;
      if (arm_p || (arm_e && (dq_i == CMD_CHIP || dq_i == CMD_SECTOR))) begin
         if (arm_p) mem[int'(addr_i)] = dq_i;
         ers = arm_e;
         prog_d = dq_i;
         {arm_p, arm_e} = 2'b00;
         left = busy_cyc;
      end else if (susp && dq_i == CMD_RESUME) susp = 1'b0;
      else if (left > 0 && dq_i == CMD_SUSP) susp = 1'b1; // halts at once
      else begin
         arm_p = dq_i == CMD_PROG;
         arm_e = arm_e || dq_i == CMD_ERASE;
      end
   end
   always @(posedge clk_i) if (left > 0 && !susp) left--;
   // released bus shows the inverse of the last word
   always @(clk_i or rd) begin
      dq_o = !rd ? ~last_q : mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 16'(addr_i);
      if (rd && susp) {dq_o[7], dq_o[6], dq_o[2]} = {2'b11, tog};
      else if (rd && left > 0)
         {dq_o[7], dq_o[6], dq_o[2]} = {~ers & ~prog_d[7], tog, ers ? tog : 1'b1};
   end
   always @(negedge rd) begin
      last_q = dq_o;
      tog = !tog;
   end
endmodule : flash_dev_model

//--- test/test_flash_ctl.sv
module test_flash_ctl
   import flash_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
`define CMP(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = '0;
   logic [3:0] sel = '0;
   logic [31:0] wdat = '0, rdat, rq;
   logic ack, irq, ce_n, oe_n, we_n, dq_oe;
   logic [ADDR_W-1:0] f_addr, a;
   logic [DATA_W-1:0] dq_o, dev_q, d;
   wire [DATA_W-1:0] dq = dq_oe ? dq_o : dev_q;
   int n_mismatch = 0, comparisons = 0;
   typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
   note_t notes[$];
   always #5 clk_i = ~clk_i;
   flash_ctl #(.PROG_LIMIT(400), .PROG_ACC_LIMIT(150), .CHIP_LIMIT(500), .CHIP_ACC_LIMIT(150),
      .SECTOR_LIMIT(500)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq_o(irq), .fl_addr_o(f_addr), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n),
      .fl_we_n_o(we_n), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe), .fl_dq_i(dq));
   flash_dev_model dev (.clk_i, .addr_i(f_addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .dq_i(dq), .dq_o(dev_q));
   always @(posedge clk_i) if (ack === 1'b1 && !we && notes.size() > 0) begin : mon
      note_t n;
      n = notes.pop_front();
      if (n.m != 0) `CMP("wb_dat_o", n.e & n.m, rdat & n.m)
   end
   task automatic complete_run();
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] v, m);
      int t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      sel <= 4'hf;
      wdat <= w ? v : 32'h0;
      if (!w) notes.push_back('{v, m});
      do @(posedge clk_i); while (ack !== 1'b1 && ++t < 9);
      if (t >= 9) n_mismatch++;
      rq = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic op(input logic [2:0] o, input logic acc);
      bus(1, REG_ADDR, 32'(a), 0);
      bus(1, REG_WDATA, 32'(d), 0);
      bus(1, REG_CTRL, {27'h0, acc, o, 1'b1}, 0);
   endtask : op
   task automatic fin(input logic [1:0] ev, m);
      int t = 0;
      while (irq !== 1'b1 && t++ < 3000) @(posedge clk_i);
      if (irq !== 1'b1) n_mismatch++;
      bus(0, REG_IRQ, 32'(ev), 32'(m));
      bus(1, REG_IRQ, 32'h3, 0);
      bus(0, REG_STATUS, {30'h0, ev[1], 1'b0}, {30'h0, m[1], 1'b1});
      `CMP("irq_o", 1'b0, irq)
   endtask : fin
   initial begin
      void'($urandom(55497));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(0, REG_STATUS, 0, '1);
      bus(0, REG_IRQ, 0, '1);
      bus(0, REG_MASK, 0, '1);
      bus(1, 8'h24, '1, 0);
      bus(0, 8'h24, 0, '1);
      bus(1, REG_MASK, 3, 0);
      for (int i = 0; i < 2; i++) begin
         a = 20'($urandom);
         d = 16'($urandom);
         op(OP_PROGRAM, i[0]);
         fin({i[0], 1'b1}, 2'b11);
         bus(0, REG_CTRL, {27'h0, i[0], OP_PROGRAM, 1'b0}, 32'h1f);
         if (i == 0) bus(0, REG_RDATA, 32'(d), 32'hffff);
         `CMP("prog_word", {a, d}, {dev.last_a, dev.last_d})
         repeat (300) @(posedge clk_i);
      end
      op(OP_READ, 0);
      fin(2'b01, 2'b11);
      bus(0, REG_RDATA, 32'(d), 32'hffff);
      for (int i = 0; i < 3; i++) begin
         op(i == 1 ? OP_SECTOR_ERASE : OP_CHIP_ERASE, i == 2);
         fin({i == 2, 1'b1}, 2'b11);
         `CMP("erase_addr", i == 1 ? a : 20'h555, dev.last_a)
         `CMP("erase_data", i == 1 ? CMD_SECTOR : CMD_CHIP, dev.last_d)
         repeat (300) @(posedge clk_i);
      end
      dev.busy_cyc = 900;
      op(OP_SECTOR_ERASE, 0);
      fin(2'b11, 2'b11);
      op(OP_SUSPEND, 0);
      fin(2'b01, 2'b11);
      bus(0, REG_RDATA, 32'hc0, 32'hc0);
      op(OP_RESUME, 0);
      fin(2'b01, 2'b01);
      `CMP("resume_cmd", CMD_RESUME, dev.last_d)
      dev.busy_cyc = 200;
      repeat (1000) @(posedge clk_i);
      bus(1, REG_MASK, 0, 0);
      op(OP_WRITE, 0);
      do bus(0, REG_STATUS, 0, 0); while (rq[0] === 1'b1);
      `CMP("irq_o", 1'b0, irq)
      `CMP("write_word", {a, d}, {dev.last_a, dev.last_d})
      bus(1, REG_MASK, 1, 0);
      `CMP("irq_o", 1'b1, irq)
      bus(1, REG_IRQ, 1, 0);
      `CMP("irq_o", 1'b0, irq)
      complete_run();
   end
   initial begin
      #500_000;
      n_mismatch++;
      complete_run();
   end
endmodule : test_flash_ctl
